// ==== logic/memmap_pkg.sv ====
`default_nettype none
package memmap_pkg;
  localparam int PC_W = 11;
  localparam int PMEM_AW = 10;
  localparam logic [10:0] RESET_VECTOR = 11'h000;
  localparam logic [9:0] CAL_ADDR = 10'h3FF;
  localparam int PMEM_W = 12;
  // data space: 32 file addresses per bank, 4 banks max
  localparam int FADDR_W = 5;
  localparam logic [4:0] ADDR_INDF = 5'h00;
  localparam logic [4:0] ADDR_TMR = 5'h01;
  localparam logic [4:0] ADDR_PC_LOW = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_FSP = 5'h04;
  localparam logic [4:0] ADDR_OSCCAL = 5'h05;
  localparam logic [4:0] ADDR_PORTB = 5'h06;
  localparam logic [4:0] ADDR_PORTC = 5'h07;
  localparam logic [4:0] SFR_COUNT_LARGE = 5'h08;
  localparam logic [4:0] SFR_COUNT_SMALL = 5'h07;
  localparam logic [4:0] UNBANKED_END = 5'h10;
  localparam int GPR_DEPTH = 128;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_PA0 = 5;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] FSP_RESET = 8'h00;
endpackage
`default_nettype wire

// ==== logic/memory_map_and_status_reg.sv ====
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Function
// RQ1: eleven-bit program counter spanning a 2K by 12 program space.
// RQ2: only low 1K words exist; higher fetch addresses wrap into them.
// RQ3: execution starts from address zero after reset.
// RQ4: last program word holds oscillator calibration; never overwritten.
// RQ5: data memory is byte register file of special and general registers.
// RQ6: large variant: 8 special, 8 unbanked, 64 banked general registers.
// RQ7: small variants: 7 special, 9 unbanked, 16 or 32 banked registers.
// RQ8: general registers reached directly or via the file select pointer.
// RQ9: special registers include timer, counter low, status, ports, pointer.
// RQ10: status holds ALU flags, reset-cause flags and page preselect.
// RQ11: any instruction may write status like any file register.
// RQ12: flag-updating instruction writes drop Z, DC, C; results used instead.
// RQ13: timeout and power-down flags ignore writes; device logic only.
// RQ14: software should alter status only by bit set, bit clear, move.
// RQ15: status register lives at data address three.
// RQ16: wrap realised by dropping the program counter top bit.
module memory_map_and_status_reg #(
  parameter bit LARGE = 1'b1,
  parameter int BANKED = 64
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // program counter control
  input wire logic i_pc_load,
  input wire logic [10:0] i_pc_value,
  input wire logic i_pc_step,
  // file access
  input wire logic [4:0] i_file_addr,
  input wire logic [1:0] i_bank,
  input wire logic i_file_we,
  input wire logic [7:0] i_file_wdata,
  // flag results of the executing instruction
  input wire logic i_flags_upd,
  input wire logic [2:0] i_flags_val,
  // device-logic reset-cause updates
  input wire logic i_to_set,
  input wire logic i_to_clr,
  input wire logic i_pd_set,
  input wire logic i_pd_clr,
  // external special registers
  input wire logic [7:0] i_timer_count_register,
  input wire logic [7:0] i_port_b,
  input wire logic [7:0] i_port_c,
  input wire logic [7:0] i_osc_cal,
  // outputs
  output logic [10:0] o_program_counter,
  output logic [9:0] o_pmem_addr,
  output logic [7:0] o_file_rdata,
  output logic [7:0] o_status,
  output logic [7:0] o_file_select_pointer
);
  typedef struct packed {
    logic [10:0] pc;
    logic [7:0] status;
    logic [7:0] fsp;
    logic [7:0] rdata;
  } state_t;
  state_t st_reg, st_next;
  logic [7:0] general_purpose_registers [0:memmap_pkg::GPR_DEPTH-1];
  logic [4:0] eff_addr;
  logic [1:0] eff_bank;
  logic is_gpr;
  logic [6:0] gpr_idx;
  logic [10:0] pc_next_val;

  // map file address and bank to a flat general register index
  function automatic logic [6:0] gpr_index(input logic [4:0] a,
                                           input logic [1:0] b);
    if (a < memmap_pkg::UNBANKED_END)
      gpr_index = {2'h0, a};
    else
      // 16 per bank above the unbanked 16; bank 3 must not alias slot 15
      gpr_index = {1'b0, b, a[3:0]} + 7'h10;
  endfunction

  function automatic logic sfr_hit(input logic [4:0] a);
    sfr_hit = LARGE ? (a < memmap_pkg::SFR_COUNT_LARGE)
                    : (a < memmap_pkg::SFR_COUNT_SMALL); // [RQ6] [RQ7]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // indirect when addressing slot zero [RQ8]
    if (i_file_addr == memmap_pkg::ADDR_INDF) begin
      eff_addr = st_reg.fsp[4:0];
      eff_bank = st_reg.fsp[6:5];
    end else begin
      eff_addr = i_file_addr;
      eff_bank = i_bank;
    end
    is_gpr = !sfr_hit(eff_addr) && (eff_addr >= memmap_pkg::UNBANKED_END
             || eff_addr >= (LARGE ? memmap_pkg::SFR_COUNT_LARGE
                                   : memmap_pkg::SFR_COUNT_SMALL)); // [RQ5]
    // banked span limited by variant size
    gpr_idx = gpr_index(eff_addr,
                        eff_bank & 2'((BANKED / 16) - 1)); // [RQ7]
  end

  always_comb begin
    st_next = st_reg;
    pc_next_val = st_reg.pc + 11'h001;
    if (i_pc_load)
      st_next.pc = i_pc_value; // [RQ1]
    else if (i_pc_step)
      st_next.pc = pc_next_val;
    if (i_file_we && eff_addr == memmap_pkg::ADDR_PC_LOW)
      st_next.pc[7:0] = i_file_wdata;
    if (i_file_we && eff_addr == memmap_pkg::ADDR_STATUS) begin
      // [RQ11] [RQ15]
      st_next.status[7:5] = i_file_wdata[7:5];
      st_next.status[2:0] = i_file_wdata[2:0];
    end
    if (i_file_we && eff_addr == memmap_pkg::ADDR_FSP)
      st_next.fsp = i_file_wdata;
    // computed flags win over the written ones [RQ12] [RQ10]
    if (i_flags_upd)
      st_next.status[2:0] = i_flags_val;
    // only device logic moves these; set wins [RQ13]
    if (i_to_clr)
      st_next.status[memmap_pkg::ST_TO] = 1'b0;
    if (i_to_set)
      st_next.status[memmap_pkg::ST_TO] = 1'b1;
    if (i_pd_clr)
      st_next.status[memmap_pkg::ST_PD] = 1'b0;
    if (i_pd_set)
      st_next.status[memmap_pkg::ST_PD] = 1'b1;
    // registered read of the special and general registers [RQ9]
    case (eff_addr)
      memmap_pkg::ADDR_INDF: st_next.rdata = 8'h00;
      memmap_pkg::ADDR_TMR: st_next.rdata = i_timer_count_register;
      memmap_pkg::ADDR_PC_LOW: st_next.rdata = st_reg.pc[7:0];
      memmap_pkg::ADDR_STATUS: st_next.rdata = st_reg.status;
      memmap_pkg::ADDR_FSP: st_next.rdata = st_reg.fsp;
      memmap_pkg::ADDR_OSCCAL: st_next.rdata = i_osc_cal;
      memmap_pkg::ADDR_PORTB: st_next.rdata = i_port_b;
      default: st_next.rdata = is_gpr ? general_purpose_registers[gpr_idx] : i_port_c;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg.pc <= memmap_pkg::RESET_VECTOR; // [RQ3]
      st_reg.status <= memmap_pkg::STATUS_RESET;
      st_reg.fsp <= memmap_pkg::FSP_RESET;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_file_we && is_gpr)
      general_purpose_registers[gpr_idx] <= i_file_wdata; // [RQ8]
  end

  // program store is external; calibration word at the top is read only
  assign o_program_counter = st_reg.pc;
  assign o_pmem_addr = st_reg.pc[9:0]; // [RQ2] [RQ16] [RQ4]
  assign o_file_rdata = st_reg.rdata;
  assign o_status = st_reg.status;
  assign o_file_select_pointer = st_reg.fsp;

  ////////////////////////////////////////////////////////////////////////////
  pc_reset_a: assert property (@(posedge i_core_clk) // [RQ3]
    $rose(i_rstn) |-> o_program_counter == 11'h000)
    else $error("pc not zero after reset");
  pmem_wrap_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_pmem_addr == o_program_counter[9:0]) // [RQ2]
    else $error("program address not wrapped");
  flags_win_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_flags_upd |=> o_status[2:0] == $past(i_flags_val)) // [RQ12]
    else $error("computed flags lost");
  to_locked_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !i_to_set && !i_to_clr && !i_pd_set && !i_pd_clr
    |=> $stable(o_status[4:3])) // [RQ13]
    else $error("reset-cause flag written");
  status_wr_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_file_we && eff_addr == 5'h03 |=>
    o_status[7:5] == $past(i_file_wdata[7:5])) // [RQ11]
    else $error("status write lost");
  pc_step_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_pc_step && !i_pc_load && !i_file_we |=>
    o_program_counter == $past(o_program_counter) + 11'h001) // [RQ1]
    else $error("pc did not step");
endmodule // memory_map_and_status_reg
`default_nettype wire

// ==== verification/core_side_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module core_side_model (
  // clock
  input wire logic i_core_clk,
  // read-through special registers
  output logic [7:0] o_timer_count_register,
  output logic [7:0] o_port_b,
  output logic [7:0] o_port_c,
  output logic [7:0] o_osc_cal
);
  // running count, so a stale read-through shows up
  initial begin
    o_timer_count_register = 8'h00;
    forever begin
      @(posedge i_core_clk);
      o_timer_count_register <= o_timer_count_register + 8'h01;
    end
  end
  assign o_port_b = 8'hA5;
  assign o_port_c = 8'h3C;
  assign o_osc_cal = 8'h96;
endmodule // core_side_model
`default_nettype wire

// ==== verification/memory_map_and_status_reg_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
  num_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
  end
module memory_map_and_status_reg_tb;
  logic clk = 1'b0, rstn = 1'b0, load = 1'b0, step = 1'b0, we = 1'b0;
  logic upd = 1'b0, to_set = 1'b0, to_clr = 1'b0, pd_clr = 1'b0;
  logic pd_set = 1'b0;
  logic [10:0] pcv = 11'h000, pc;
  logic [4:0] addr = 5'h00;
  logic [1:0] bank = 2'h0;
  logic [7:0] wdata = 8'h00, tmr, pb, pcc, cal, rdata, st, fsp;
  logic [2:0] fv = 3'h0;
  logic [9:0] pma;
  int mismatches = 0;
  int num_checks = 0;
  always #4 clk = ~clk;
  core_side_model far (.i_core_clk(clk), .o_timer_count_register(tmr),
    .o_port_b(pb), .o_port_c(pcc), .o_osc_cal(cal));
  memory_map_and_status_reg #(.LARGE(1'b1), .BANKED(64)) DUT (
    .i_core_clk(clk), .i_rstn(rstn), .i_pc_load(load), .i_pc_value(pcv),
    .i_pc_step(step), .i_file_addr(addr), .i_bank(bank), .i_file_we(we),
    .i_file_wdata(wdata), .i_flags_upd(upd), .i_flags_val(fv),
    .i_to_set(to_set), .i_to_clr(to_clr), .i_pd_set(pd_set),
    .i_pd_clr(pd_clr), .i_timer_count_register(tmr), .i_port_b(pb),
    .i_port_c(pcc), .i_osc_cal(cal), .o_program_counter(pc),
    .o_pmem_addr(pma), .o_file_rdata(rdata), .o_status(st),
    .o_file_select_pointer(fsp));
  ////////////////////////////////////////
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic pc_op(input logic ld, input logic sp, input logic [10:0] v);
    load = ld;
    step = sp;
    pcv = v;
    @(negedge clk);
    load = 1'b0;
    step = 1'b0;
    // idle edge so a following call never re-raises a strobe at once
    @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [1:0] b,
    input logic [7:0] d, input logic u, input logic [2:0] f);
    addr = a;
    bank = b;
    wdata = d;
    upd = u;
    fv = f;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    upd = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [1:0] b,
    input logic [7:0] e);
    addr = a;
    bank = b;
    @(negedge clk);
    `CHK("rdata", e, rdata)
  endtask
  task automatic pc_wrap();
    pc_op(1'b0, 1'b1, 11'h000);
    `CHK("pc", 11'h001, pc)
    pc_op(1'b1, 1'b0, 11'h7FF);
    `CHK("pmem", 10'h3FF, pma)
    pc_op(1'b0, 1'b1, 11'h000);
    `CHK("pc", 11'h000, pc)
    pc_op(1'b1, 1'b1, 11'h400);
    `CHK("pmem", 10'h000, pma)
  endtask
  task automatic status_protect();
    wr(5'h03, 2'h0, 8'h00, 1'b0, 3'h0);
    `CHK("status", 8'h18, st)
    wr(5'h03, 2'h0, 8'hFF, 1'b1, 3'h2);
    `CHK("status", 8'hFA, st)
    to_clr = 1'b1;
    pd_clr = 1'b1;
    @(negedge clk);
    to_clr = 1'b0;
    pd_clr = 1'b0;
    `CHK("status", 8'hE2, st)
    wr(5'h03, 2'h0, 8'hF8, 1'b0, 3'h0);
    `CHK("status", 8'hE0, st)
    to_set = 1'b1;
    @(negedge clk);
    to_set = 1'b0;
    `CHK("status", 8'hF0, st)
    pd_set = 1'b1;
    pd_clr = 1'b1;
    @(negedge clk);
    pd_set = 1'b0;
    pd_clr = 1'b0;
    `CHK("status", 8'hF8, st)
  endtask
  task automatic file_access();
    wr(5'h15, 2'h2, 8'hC3, 1'b0, 3'h0);
    wr(5'h15, 2'h1, 8'h5A, 1'b0, 3'h0);
    wr(5'h0F, 2'h0, 8'h7E, 1'b0, 3'h0);
    wr(5'h1F, 2'h3, 8'h81, 1'b0, 3'h0);
    wr(5'h04, 2'h0, 8'h55, 1'b0, 3'h0);
    `CHK("pointer", 8'h55, fsp)
    rd(5'h00, 2'h0, 8'hC3);
    rd(5'h15, 2'h1, 8'h5A);
    rd(5'h0F, 2'h0, 8'h7E);
    rd(5'h1F, 2'h3, 8'h81);
    rd(5'h01, 2'h0, tmr);
    rd(5'h02, 2'h0, 8'h00);
    rd(5'h03, 2'h0, 8'hF8);
  endtask
  task automatic mid_reset();
    pc_op(1'b1, 1'b0, 11'h155);
    `CHK("pc", 11'h155, pc)
    rstn = 1'b0;
    @(negedge clk);
    `CHK("pc", 11'h000, pc)
    `CHK("status", 8'h18, st)
    `CHK("pointer", 8'h00, fsp)
    rstn = 1'b1;
    pc_op(1'b0, 1'b1, 11'h000);
    `CHK("pc", 11'h001, pc)
  endtask
  // bound the run so a stuck bench still reports
  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    `CHK("pc", 11'h000, pc)
    `CHK("status", 8'h18, st)
    pc_wrap();
    status_protect();
    file_access();
    mid_reset();
    stop_test();
  end
endmodule // memory_map_and_status_reg_tb
`default_nettype wire
